// >>> verilog/mac_consts.svh
`ifndef MAC_CONSTS_SVH
`define MAC_CONSTS_SVH

// Register indices; byte address is four times the index
`define MAC_IDX_LOW_LIMIT   10'h089
`define MAC_IDX_SCRATCH     10'h08a
`define MAC_IDX_CFG_ONE     10'h08b
`define MAC_IDX_CFG_TWO     10'h08c
`define MAC_IDX_STATUS      10'h0a0
`define MAC_IDX_MASK        10'h0a1
`define MAC_IDX_CONTROL     10'h0a2
`define MAC_IDX_STATE       10'h0a3

// Reset values
`define MAC_RST_LOW_LIMIT   16'h8000
`define MAC_RST_SCRATCH     16'h5555
`define MAC_RST_CFG_ONE     16'h8010
`define MAC_RST_CFG_TWO     16'h0000

// Writable bits of the configuration words
`define MAC_CFG_ONE_WMASK   16'h87ff
`define MAC_CFG_TWO_WMASK   16'hc703

// Field positions of the first configuration word
`define MAC_EN_BIT          15
`define MAC_CMB_BIT         10
`define MAC_SRC_CH_MSB      9
`define MAC_SRC_CH_LSB      7
`define MAC_SNK_CH_MSB      6
`define MAC_SNK_CH_LSB      4
`define MAC_SRC_CUR_MSB     3
`define MAC_SRC_CUR_LSB     2
`define MAC_SNK_CUR_MSB     1
`define MAC_SNK_CUR_LSB     0

// Field positions of the second configuration word
`define MAC_MODE_MSB        15
`define MAC_MODE_LSB        14
`define MAC_DLY_MSB         10
`define MAC_DLY_LSB         8
`define MAC_OSR_MSB         1
`define MAC_OSR_LSB         0

// Sequencer modes
`define MAC_MODE_SHOT       2'h0
`define MAC_MODE_SHOT_TRIG  2'h1

// Interrupt status bits
`define MAC_IRQ_LOW         0
`define MAC_IRQ_SEQ_DONE    1
`define MAC_IRQ_CFG_BUSY    2
`define MAC_IRQ_W           3

// Control and state bits
`define MAC_CTL_LAUNCH_BIT  0
`define MAC_STATE_RUN_BIT   18

// Test current magnitudes in microamps
`define MAC_UA_OFF          8'h00
`define MAC_UA_LOW          8'h04
`define MAC_UA_MID          8'h28
`define MAC_UA_HIGH         8'hf0

// Most negative full-scale threshold
`define MAC_NEG_FS          16'h8000

`endif

// >>> verilog/mac_pkg.sv
package mac_pkg;
    typedef logic [15:0] mac_word_t;
    typedef logic [1:0]  mac_code_t;
    typedef enum {
        MAC_SEQ_IDLE,
        MAC_SEQ_RUN
    } mac_seq_e;
endpackage

// >>> verilog/mac_low_cmp.sv
`include "mac_consts.svh"

module mac_low_cmp
    import mac_pkg::*;
(
    input  wire logic      i_clk,
    input  wire logic      i_rst_n,
    input  wire logic      i_fast_valid,
    input  wire mac_word_t i_fast_data,
    input  wire mac_word_t i_limit,
    output logic           o_below
);
    logic below_now;

    // Signed compare, most negative limit never trips
    always_comb begin
        below_now = ($signed(i_fast_data) < $signed(i_limit));
        if (i_limit == `MAC_NEG_FS) begin
            below_now = 1'b0;
        end
    end

    // Result held between fast-filter outputs
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_below <= 1'b0;
        end else if (i_fast_valid) begin
            o_below <= below_now;
        end
    end
endmodule // mac_low_cmp

// >>> verilog/mac_regs.sv
`include "mac_consts.svh"

// Overview of operation
// - Low limit is signed 16-bit, compared with first converter fast-filter result.
// - Low-limit event raised while fast-filter result is below the limit.
// - Limit at most negative full scale never raises the event.
// - Scratch word fully read/write, no effect, part of integrity check.
// - Config-one bit 15 enables multiplexed converter, resets to one.
// - Disable, standby or power-down clear result and sequence counter.
// - Bit 10 switches common-mode buffer on input seven, resets off.
// - Bits 9:7 route test source to input n, reset zero.
// - Bits 6:4 route test sink to input n, reset input one.
// - Source current bits 3:2: off, 4 uA, 240 uA; reset off.
// - Sink current bits 1:0: off, 4, 40, 240 uA; reset off.
// - Reserved bits 14:11 of config one always read zero.
// - Sequence launch aborts any running sequence and restarts it.
module mac_regs
    import mac_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_fast_valid,
    input  wire mac_word_t   i_fast_data,
    input  wire logic        i_conv_valid,
    input  wire mac_word_t   i_conv_data,
    input  wire logic        i_step_done,
    input  wire logic        i_conv_start_trigger,
    input  wire logic        i_standby,
    input  wire logic        i_power_down,
    output logic             o_low_limit_event,
    output logic             o_mux_converter_enable,
    output logic             o_common_mode_buffer_enable,
    output logic      [2:0]  o_test_source_channel,
    output logic      [2:0]  o_test_sink_channel,
    output logic      [7:0]  o_test_source_route,
    output logic      [7:0]  o_test_sink_route,
    output logic      [7:0]  o_test_source_ua,
    output logic      [7:0]  o_test_sink_ua,
    output mac_code_t        o_sequencer_mode,
    output logic      [2:0]  o_channel_settle_delay,
    output mac_code_t        o_mux_oversampling_ratio,
    output logic             o_sequence_launch,
    output mac_code_t        o_sequence_counter,
    output mac_word_t        o_conv_result,
    output logic             o_irq
);
    mac_word_t                overcurrent_low_limit_a;
    mac_word_t                scratch_word;
    mac_word_t                mux_converter_config_one;
    mac_word_t                mux_converter_config_two;
    logic [`MAC_IRQ_W-1:0]    irq_status;
    logic [`MAC_IRQ_W-1:0]    irq_mask;
    logic [`MAC_IRQ_W-1:0]    irq_events;
    logic [1:0]               pin_meta;
    logic [1:0]               pin_sync;
    logic                     quiet;
    logic                     below;
    logic                     below_q;
    logic                     setup;
    logic                     access;
    logic                     wr_en;
    logic                     rd_done;
    logic                     mapped;
    logic [9:0]               word_idx;
    logic [31:0]              next_prdata;
    logic                     launch_req;
    logic                     seq_wrap;
    mac_seq_e                 seq_state;
    mac_seq_e                 next_seq_state;

    // Register index hit on an aligned word
    function automatic logic addr_hit(input logic [11:0] addr, input logic [9:0] idx);
        addr_hit = (addr[11:2] == idx) && (addr[1:0] == 2'h0);
    endfunction

    // Microamp value of a test current code
    function automatic logic [7:0] current_ua(input mac_code_t code, input logic sink);
        case (code)
            2'h1: begin
                current_ua = `MAC_UA_LOW;
            end
            2'h2: begin
                // Middle step exists on the sink only
                current_ua = sink ? `MAC_UA_MID : `MAC_UA_OFF;
            end
            2'h3: begin
                current_ua = `MAC_UA_HIGH;
            end
            default: begin
                current_ua = `MAC_UA_OFF;
            end
        endcase
    endfunction

    // Standby and power-down pins synchronised before use
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            pin_meta <= 2'h0;
            pin_sync <= 2'h0;
        end else begin
            pin_meta <= {i_power_down, i_standby};
            pin_sync <= pin_meta;
        end
    end

    assign quiet = !mux_converter_config_one[`MAC_EN_BIT] || (pin_sync != 2'h0);

    // Low-limit comparator
    mac_low_cmp u_low_cmp (
        .i_clk        (i_clk),
        .i_rst_n      (i_rst_n),
        .i_fast_valid (i_fast_valid),
        .i_fast_data  (i_fast_data),
        .i_limit      (overcurrent_low_limit_a),
        .o_below      (below)
    );

    assign o_low_limit_event = below;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            below_q <= 1'b0;
        end else begin
            below_q <= below;
        end
    end

    // APB decode; zero wait states
    assign setup    = i_psel && !i_penable;
    assign access   = i_psel && i_penable;
    assign word_idx = i_paddr[11:2];
    assign o_pready = 1'b1;

    always_comb begin
        mapped = addr_hit(i_paddr, `MAC_IDX_LOW_LIMIT)
              || addr_hit(i_paddr, `MAC_IDX_SCRATCH)
              || addr_hit(i_paddr, `MAC_IDX_CFG_ONE)
              || addr_hit(i_paddr, `MAC_IDX_CFG_TWO)
              || addr_hit(i_paddr, `MAC_IDX_STATUS)
              || addr_hit(i_paddr, `MAC_IDX_MASK)
              || addr_hit(i_paddr, `MAC_IDX_CONTROL)
              || addr_hit(i_paddr, `MAC_IDX_STATE);
    end

    assign o_pslverr = access && !mapped;
    assign wr_en     = access && i_pwrite && mapped;
    assign rd_done   = access && !i_pwrite && mapped;

    // Read data sampled in the setup phase so it comes from a flip-flop
    always_comb begin
        next_prdata = 32'h0;
        if (i_paddr[1:0] == 2'h0) begin
            case (word_idx)
                `MAC_IDX_LOW_LIMIT: begin
                    next_prdata[15:0] = overcurrent_low_limit_a;
                end
                `MAC_IDX_SCRATCH: begin
                    next_prdata[15:0] = scratch_word;
                end
                `MAC_IDX_CFG_ONE: begin
                    next_prdata[15:0] = mux_converter_config_one;
                end
                `MAC_IDX_CFG_TWO: begin
                    next_prdata[15:0] = mux_converter_config_two;
                end
                `MAC_IDX_STATUS: begin
                    next_prdata[`MAC_IRQ_W-1:0] = irq_status;
                end
                `MAC_IDX_MASK: begin
                    next_prdata[`MAC_IRQ_W-1:0] = irq_mask;
                end
                `MAC_IDX_STATE: begin
                    next_prdata[15:0]  = o_conv_result;
                    next_prdata[17:16] = o_sequence_counter;
                    next_prdata[`MAC_STATE_RUN_BIT] = (seq_state == MAC_SEQ_RUN);
                end
                default: begin
                    next_prdata = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_prdata <= 32'h0;
        end else if (setup) begin
            o_prdata <= next_prdata;
        end
    end

    // Threshold and scratch words
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            overcurrent_low_limit_a <= `MAC_RST_LOW_LIMIT;
            scratch_word            <= `MAC_RST_SCRATCH;
        end else if (wr_en) begin
            if (addr_hit(i_paddr, `MAC_IDX_LOW_LIMIT)) begin
                overcurrent_low_limit_a <= i_pwdata[15:0];
            end
            if (addr_hit(i_paddr, `MAC_IDX_SCRATCH)) begin
                scratch_word <= i_pwdata[15:0];
            end
        end
    end

    // Configuration words; reserved bits never stored
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            mux_converter_config_one <= `MAC_RST_CFG_ONE;
            mux_converter_config_two <= `MAC_RST_CFG_TWO;
        end else if (wr_en) begin
            if (addr_hit(i_paddr, `MAC_IDX_CFG_ONE)) begin
                mux_converter_config_one <= i_pwdata[15:0] & `MAC_CFG_ONE_WMASK;
            end
            if (addr_hit(i_paddr, `MAC_IDX_CFG_TWO)) begin
                mux_converter_config_two <= i_pwdata[15:0] & `MAC_CFG_TWO_WMASK;
            end
        end
    end

    // Configuration fields out to the analog side
    assign o_mux_converter_enable      = mux_converter_config_one[`MAC_EN_BIT];
    assign o_common_mode_buffer_enable = mux_converter_config_one[`MAC_CMB_BIT];
    assign o_test_source_channel =
        mux_converter_config_one[`MAC_SRC_CH_MSB:`MAC_SRC_CH_LSB];
    assign o_test_sink_channel =
        mux_converter_config_one[`MAC_SNK_CH_MSB:`MAC_SNK_CH_LSB];
    assign o_test_source_ua = current_ua(
        mux_converter_config_one[`MAC_SRC_CUR_MSB:`MAC_SRC_CUR_LSB], 1'b0);
    assign o_test_sink_ua = current_ua(
        mux_converter_config_one[`MAC_SNK_CUR_MSB:`MAC_SNK_CUR_LSB], 1'b1);
    assign o_sequencer_mode = mux_converter_config_two[`MAC_MODE_MSB:`MAC_MODE_LSB];
    assign o_channel_settle_delay = mux_converter_config_two[`MAC_DLY_MSB:`MAC_DLY_LSB];
    assign o_mux_oversampling_ratio = mux_converter_config_two[`MAC_OSR_MSB:`MAC_OSR_LSB];

    // One-hot routing, idle while the current is off
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_route
            assign o_test_source_route[g] = (o_test_source_channel == 3'(g))
                                         && (o_test_source_ua != `MAC_UA_OFF);
            assign o_test_sink_route[g]   = (o_test_sink_channel == 3'(g))
                                         && (o_test_sink_ua != `MAC_UA_OFF);
        end
    endgenerate

    // Launch is write-one; trigger only starts an idle sequence
    always_comb begin
        launch_req = wr_en && addr_hit(i_paddr, `MAC_IDX_CONTROL)
                  && i_pwdata[`MAC_CTL_LAUNCH_BIT];
    end

    assign seq_wrap = i_step_done && (o_sequence_counter == 2'h3);

    always_comb begin
        next_seq_state = seq_state;
        case (seq_state)
            MAC_SEQ_IDLE: begin
                if (launch_req) begin
                    next_seq_state = MAC_SEQ_RUN;
                end else if (i_conv_start_trigger
                          && o_sequencer_mode == `MAC_MODE_SHOT_TRIG) begin
                    next_seq_state = MAC_SEQ_RUN;
                end
            end
            MAC_SEQ_RUN: begin
                // Continuous modes never leave on their own
                if (launch_req) begin
                    next_seq_state = MAC_SEQ_RUN;
                end else if (seq_wrap && !o_sequencer_mode[1]) begin
                    next_seq_state = MAC_SEQ_IDLE;
                end
            end
            default: begin
                next_seq_state = MAC_SEQ_IDLE;
            end
        endcase
        if (quiet) begin
            next_seq_state = MAC_SEQ_IDLE;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            seq_state <= MAC_SEQ_IDLE;
        end else begin
            seq_state <= next_seq_state;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_sequence_launch <= 1'b0;
        end else begin
            o_sequence_launch <= !quiet && next_seq_state == MAC_SEQ_RUN
                              && (launch_req || seq_state == MAC_SEQ_IDLE);
        end
    end

    // Sequence counter; launch restarts from step zero
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_sequence_counter <= 2'h0;
        end else if (quiet || launch_req) begin
            o_sequence_counter <= 2'h0;
        end else if (i_step_done && seq_state == MAC_SEQ_RUN) begin
            o_sequence_counter <= o_sequence_counter + 2'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_conv_result <= 16'h0;
        end else if (quiet) begin
            o_conv_result <= 16'h0;
        end else if (i_conv_valid) begin
            o_conv_result <= i_conv_data;
        end
    end

    // Interrupt events; set beats the read clear
    always_comb begin
        irq_events = '0;
        irq_events[`MAC_IRQ_LOW]      = below && !below_q;
        irq_events[`MAC_IRQ_SEQ_DONE] = seq_wrap && seq_state == MAC_SEQ_RUN;
        // Flags a second configuration word write while the converter enable bit is set
        irq_events[`MAC_IRQ_CFG_BUSY] = wr_en && mux_converter_config_one[`MAC_EN_BIT]
                                     && addr_hit(i_paddr, `MAC_IDX_CFG_TWO);
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            irq_status <= '0;
        end else if (rd_done && addr_hit(i_paddr, `MAC_IDX_STATUS)) begin
            irq_status <= irq_events;
        end else begin
            irq_status <= irq_status | irq_events;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            irq_mask <= '0;
        end else if (wr_en && addr_hit(i_paddr, `MAC_IDX_MASK)) begin
            irq_mask <= i_pwdata[`MAC_IRQ_W-1:0];
        end
    end

    assign o_irq = |(irq_status & irq_mask);
endmodule // mac_regs

// >>> dv/mac_regs_asserts.sv
module mac_regs_asserts
    import mac_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic        i_fast_valid,
    input wire mac_word_t   i_fast_data,
    input wire logic        o_low_limit_event,
    input wire logic        o_mux_converter_enable,
    input wire logic        o_common_mode_buffer_enable,
    input wire logic [2:0]  o_test_source_channel,
    input wire logic [2:0]  o_test_sink_channel,
    input wire logic [7:0]  o_test_source_ua,
    input wire logic [7:0]  o_test_sink_ua,
    input wire logic        o_sequence_launch,
    input wire mac_code_t   o_sequence_counter,
    input wire mac_word_t   o_conv_result
);
    logic      wr;
    logic      c1;
    logic [7:0] su;
    logic [7:0] ku;
    mac_word_t lim;
    assign wr = i_psel && i_penable && i_pwrite;
    assign c1 = wr && i_paddr == 12'h22c;
    // Code 10 on the source side is treated as off
    assign su = i_pwdata[3:2] == 2'h1 ? 8'h04 : (i_pwdata[3:2] == 2'h3 ? 8'hf0 : 8'h00);
    assign ku = i_pwdata[1] ? (i_pwdata[0] ? 8'hf0 : 8'h28) : (i_pwdata[0] ? 8'h04 : 8'h00);
    // Shadow of the limit, since the register itself is not a port
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            lim <= 16'h8000;
        end else if (wr && i_paddr == 12'h224) begin
            lim <= i_pwdata[15:0];
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    property p_low_cmp;
        i_fast_valid |=> o_low_limit_event == ($signed($past(i_fast_data)) < $signed($past(lim)));
    endproperty
    a_low_cmp: assert property (p_low_cmp)
        else $error("low event wrong");
    property p_low_off;
        i_fast_valid && lim == 16'h8000 |=> !o_low_limit_event;
    endproperty
    a_low_off: assert property (p_low_off)
        else $error("low event at neg full scale");
    property p_en;
        c1 |=> o_mux_converter_enable == $past(i_pwdata[15]);
    endproperty
    a_en: assert property (p_en)
        else $error("enable wrong");
    property p_cmb;
        c1 |=> o_common_mode_buffer_enable == $past(i_pwdata[10]);
    endproperty
    a_cmb: assert property (p_cmb)
        else $error("buffer enable wrong");
    property p_ch;
        c1 |=> o_test_source_channel == $past(i_pwdata[9:7])
            && o_test_sink_channel == $past(i_pwdata[6:4]);
    endproperty
    a_ch: assert property (p_ch)
        else $error("channel wrong");
    property p_ua;
        c1 |=> o_test_source_ua == $past(su) && o_test_sink_ua == $past(ku);
    endproperty
    a_ua: assert property (p_ua)
        else $error("current wrong");
    property p_rsv;
        i_psel && i_penable && !i_pwrite && i_paddr == 12'h22c
            |-> o_prdata[31:16] == 16'h0 && o_prdata[14:11] == 4'h0;
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved bits set");
    property p_off_clr;
        (!o_mux_converter_enable) [*2] |-> o_conv_result == 16'h0 && o_sequence_counter == 2'h0;
    endproperty
    a_off_clr: assert property (p_off_clr)
        else $error("result kept while off");
    property p_launch;
        wr && i_paddr == 12'h288 && i_pwdata[0]
            |=> o_sequence_launch && o_sequence_counter == 2'h0 ##1 !o_sequence_launch;
    endproperty
    a_launch: assert property (p_launch)
        else $error("launch pulse wrong");
endmodule // mac_regs_asserts

bind mac_regs mac_regs_asserts i_mac_regs_asserts (
    .i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
    .i_fast_valid, .i_fast_data, .o_low_limit_event, .o_mux_converter_enable,
    .o_common_mode_buffer_enable, .o_test_source_channel, .o_test_sink_channel,
    .o_test_source_ua, .o_test_sink_ua, .o_sequence_launch, .o_sequence_counter,
    .o_conv_result
);

// >>> dv/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk, i_rst_n, i_psel, i_penable, i_pwrite, er;
    logic i_fast_valid, i_conv_valid, i_step_done, i_conv_start_trigger;
    logic i_standby, i_power_down, o_pready, o_pslverr, o_low_limit_event, o_irq;
    logic o_mux_converter_enable, o_common_mode_buffer_enable, o_sequence_launch;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, rd;
    logic [15:0] i_fast_data, i_conv_data, o_conv_result;
    logic [2:0]  o_test_source_channel, o_test_sink_channel, o_channel_settle_delay;
    logic [7:0]  o_test_source_route, o_test_sink_route, o_test_source_ua, o_test_sink_ua;
    logic [1:0]  o_sequencer_mode, o_mux_oversampling_ratio, o_sequence_counter;
    int          failures, samples_checked;
    localparam logic [7:0] SRC_UA [4] = '{8'h00, 8'h04, 8'h00, 8'hf0};
    localparam logic [7:0] SNK_UA [4] = '{8'h00, 8'h04, 8'h28, 8'hf0};

    mac_regs i_mac_regs (
        .i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
        .o_pready, .o_pslverr, .i_fast_valid, .i_fast_data, .i_conv_valid, .i_conv_data,
        .i_step_done, .i_conv_start_trigger, .i_standby, .i_power_down, .o_low_limit_event,
        .o_mux_converter_enable, .o_common_mode_buffer_enable, .o_test_source_channel,
        .o_test_sink_channel, .o_test_source_route, .o_test_sink_route, .o_test_source_ua,
        .o_test_sink_ua, .o_sequencer_mode, .o_channel_settle_delay,
        .o_mux_oversampling_ratio, .o_sequence_launch, .o_sequence_counter, .o_conv_result,
        .o_irq
    );

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task test_done;
        $display("checks=%0d failures=%0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 16);
        if (o_pready !== 1'b1) begin
            failures++;
            test_done;
        end
        rd = o_prdata;
        er = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        #1;
    endtask

    task rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    // Kind 0 fast result, 1 converter result, 2 sequence step, 3 start trigger
    task pulse(input int k, input logic [15:0] v);
        @(posedge i_clk);
        i_fast_data <= v;
        i_conv_data <= v;
        i_fast_valid <= k == 0;
        i_conv_valid <= k == 1;
        i_step_done <= k == 2;
        i_conv_start_trigger <= k == 3;
        @(posedge i_clk);
        {i_fast_valid, i_conv_valid, i_step_done, i_conv_start_trigger} <= 4'b0000;
        @(posedge i_clk);
        #1;
    endtask

    task launch;
        wr(12'h288, 32'h1);
        chk(o_sequence_launch, 1'b1);
        @(posedge i_clk);
        #1;
        chk(o_sequence_launch, 1'b0);
        chk(o_sequence_counter, 2'h0);
    endtask

    task t_reset;
        rdc(12'h224, 32'h8000);
        rdc(12'h228, 32'h5555);
        rdc(12'h22c, 32'h8010);
        rdc(12'h230, 32'h0000);
        chk({o_mux_converter_enable, o_common_mode_buffer_enable}, 2'b10);
        chk({o_test_source_channel, o_test_sink_channel}, 6'o01);
        chk({o_test_source_ua, o_test_sink_ua}, 16'h0);
        // Unmapped place must refuse and read zero
        apb(1'b0, 12'h300, 32'h0);
        chk(rd, 32'h0);
        chk(er, 1'b1);
    endtask

    task t_regs;
        wr(12'h228, 32'hffffa5c3);
        rdc(12'h228, 32'h0000a5c3);
        wr(12'h228, 32'h00005a3c);
        rdc(12'h228, 32'h00005a3c);
        wr(12'h22c, 32'hffffffff);
        rdc(12'h22c, 32'h000087ff);
        chk(o_common_mode_buffer_enable, 1'b1);
        chk({o_test_source_channel, o_test_sink_channel}, 6'o77);
        wr(12'h22c, 32'h0);
        chk(o_mux_converter_enable, 1'b0);
        wr(12'h230, 32'hffffffff);
        rdc(12'h230, 32'h0000c703);
        chk({o_sequencer_mode, o_channel_settle_delay, o_mux_oversampling_ratio}, 7'h7f);
        wr(12'h230, 32'h0);
        wr(12'h22c, 32'h8010);
        rdc(12'h22c, 32'h8010);
    endtask

    task t_ua;
        for (int c = 0; c < 4; c++) begin
            wr(12'h22c, 32'h81d0 | (c << 2) | c);
            chk(o_test_source_ua, SRC_UA[c]);
            chk(o_test_sink_ua, SNK_UA[c]);
            chk(o_test_source_route, SRC_UA[c] != 0 ? 8'h08 : 8'h00);
            chk(o_test_sink_route, SNK_UA[c] != 0 ? 8'h20 : 8'h00);
        end
        wr(12'h22c, 32'h8010);
    endtask

    task t_low;
        pulse(0, 16'h8000);
        chk(o_low_limit_event, 1'b0);
        wr(12'h284, 32'h1);
        wr(12'h224, 32'hfff0);
        // Unsigned compare would trip here
        pulse(0, 16'h0005);
        chk(o_low_limit_event, 1'b0);
        pulse(0, 16'hffef);
        chk({o_low_limit_event, o_irq}, 2'b11);
        pulse(0, 16'hfff0);
        chk(o_low_limit_event, 1'b0);
        rdc(12'h280, 32'h1);
        #1;
        chk(o_irq, 1'b0);
        wr(12'h284, 32'h0);
        pulse(0, 16'hffef);
        chk({o_low_limit_event, o_irq}, 2'b10);
        rdc(12'h280, 32'h1);
        wr(12'h224, 32'h8000);
        pulse(0, 16'h8000);
        chk(o_low_limit_event, 1'b0);
    endtask

    // Off by enable bit, standby pin, power-down pin in turn
    task t_clear;
        for (int k = 0; k < 3; k++) begin
            pulse(1, 16'h1234);
            chk(o_conv_result, 16'h1234);
            launch;
            pulse(2, 16'h0);
            chk(o_sequence_counter, 2'h1);
            @(posedge i_clk);
            i_standby <= k == 1;
            i_power_down <= k == 2;
            if (k == 0) wr(12'h22c, 32'h0010);
            repeat (4) @(posedge i_clk);
            #1;
            chk({o_conv_result, o_sequence_counter}, 18'h0);
            pulse(1, 16'h4321);
            chk(o_conv_result, 16'h0);
            @(posedge i_clk);
            i_standby <= 1'b0;
            i_power_down <= 1'b0;
            wr(12'h22c, 32'h8010);
            repeat (4) @(posedge i_clk);
        end
    endtask

    task t_seq;
        for (int m = 0; m < 4; m++) begin
            wr(12'h22c, 32'h0010);
            wr(12'h230, m << 14);
            rdc(12'h230, m << 14);
            wr(12'h22c, 32'h8010);
            launch;
            pulse(2, 16'h0);
            pulse(2, 16'h0);
            chk(o_sequence_counter, 2'h2);
            // Relaunch mid-sequence must abort and restart
            launch;
            // Four steps wrap the counter; only the plain one-shot mode stays idle
            repeat (4) pulse(2, 16'h0);
            rdc(12'h280, 32'h2);
            pulse(3, 16'h0);
            rdc(12'h28c, m == 0 ? 32'h0 : 32'h40000);
        end
    endtask

    initial begin
        failures = 0;
        samples_checked = 0;
        {i_rst_n, i_psel, i_penable, i_pwrite, er} = 5'b0;
        {i_fast_valid, i_conv_valid, i_step_done, i_conv_start_trigger} = 4'b0;
        {i_standby, i_power_down} = 2'b0;
        i_paddr = 12'h0;
        i_pwdata = 32'h0;
        i_fast_data = 16'h0;
        i_conv_data = 16'h0;
        repeat (3) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_reset;
        t_regs;
        t_ua;
        t_low;
        t_clear;
        t_seq;
        test_done;
    end
endmodule // testbench
